// ==== logic/dgoc_pkg.sv ====
// Package for the diagnostic and output command register bank
package dgoc_pkg;

  // ----------------------------------------------------------------
  // Read addresses of the diagnostic registers
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_EVENT_KEYON   = 4'h0;
  localparam logic [3:0] ADDR_SUPPLY_SENSOR = 4'h3;
  localparam logic [3:0] ADDR_RESET_CAUSE   = 4'h7;
  localparam logic [3:0] ADDR_THERMAL_LINK  = 4'hb;
  localparam logic [3:0] ADDR_IGNITER       = 4'he;
  // Read that clears the event register instead of returning it
  localparam logic [3:0] ADDR_EVENT_CLEAR   = 4'h5;

  // ----------------------------------------------------------------
  // Command register selectors and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_CMD_ONE   = 2'h0;
  localparam logic [1:0] SEL_CMD_TWO   = 2'h1;
  localparam logic [1:0] SEL_CMD_THREE = 2'h2;
  localparam logic [7:0] CMD_RESET     = 8'h00;
  localparam logic       STEPPER_BRIDGE_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Codes and field positions
  // ----------------------------------------------------------------
  localparam logic [1:0] IGN_SHORT_GND   = 2'h0;
  localparam logic [1:0] IGN_OPEN_LOAD   = 2'h1;
  localparam logic [1:0] IGN_SHORT_BAT   = 2'h2;
  localparam logic [1:0] IGN_HEALTHY     = 2'h3;
  localparam logic [1:0] SUP_OVERLOAD    = 2'h1;
  localparam logic [1:0] SUP_OVER_V_T    = 2'h2;
  localparam logic [1:0] SUP_HEALTHY     = 2'h3;
  localparam int         CMD2_UNUSED_BIT = 5;
  localparam int         CMD3_DIR_BIT    = 7;
  localparam int         CMD3_EN_BIT     = 6;

  // ----------------------------------------------------------------
  // Timing at 20 MHz
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 20000000;
  localparam int IO_UV_MS       = 225;
  localparam int SEO_INJ_MS     = 225;
  localparam int SEO_RELAY_MS   = 600;
  localparam int IO_UV_CYCLES   = IO_UV_MS * (CLK_HZ / 1000);
  localparam int SEO_INJ_CYC    = SEO_INJ_MS * (CLK_HZ / 1000);
  localparam int SEO_RELAY_CYC  = SEO_RELAY_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------
  // Raw condition inputs from the analog side
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] igniter_fault_code;
    logic       key_on_above;
    logic       relay_driver_overcurrent_off;
    logic       crank_sensor_diag_running;
    logic       crank_sensor_generic;
    logic       crank_fully_adaptive;
    logic [1:0] supply_a_overload_ovot;
    logic [1:0] supply_b_overload_ovot;
    logic       timing_monitor_reset;
    logic       main_outputs_fault;
    logic       configurable_outputs_fault;
    logic       short_undervolt_reset;
    logic       long_undervolt_event;
    logic       logic5v_overvoltage;
    logic       logic3v3_undervoltage;
    logic       battery_overvolt_shutdown;
    logic [3:0] overtemp;
    logic [3:0] can_errors;
    logic       frame_length_error;
    logic       frame_timeout_error;
    logic       io_supply_low;
    logic       watchdog_alarm;
    logic       filtered_key_on;
  } dgoc_cond_t;

  typedef enum logic [1:0] {
    SEO_IDLE  = 2'b00,
    SEO_COUNT = 2'b01,
    SEO_DONE  = 2'b10
  } dgoc_seo_t;

endpackage

// ==== logic/dgoc_regs.sv ====
// Diagnostic status and output command register bank
`timescale 1ns/1ps
// What this block does
// - Four igniter 2-bit codes: 00 ground short, 01 open, 10 battery short, 11 ok.
// - Supply bit 6 shows relay driver off from earlier overcurrent.
// - Crank fault only in fully adaptive mode; separate diag-running bit.
// - Sensor supply codes 01 overload, 10 OV/OT, 11 ok; overload wins.
// - Separate reset-cause flags: timing monitor, short and long undervoltage.
// - Summary fault bits for main outputs/igniters and configurable outputs.
// - Flags for 5 V overvoltage, 3.3 V undervoltage, battery overvoltage shutdown.
// - Output inhibit blocks all outputs and their command data until start.
// - Inhibit not cleared by read; set by power-on, software and pin reset.
// - Four overtemperature flags in bits 7 to 4.
// - Long undervoltage event latched even when masked.
// - One CAN error bit for any of four transceiver errors.
// - Frame length error bit 1, stream time-out bit 0.
// - I/O undervoltage flag set after 225 ms continuous undervoltage.
// - Watchdog reset shown latched in bit 6 and live in bit 3.
// - Safe-off flags after 225 ms injectors and 600 ms relay outputs.
// - Safe-off only with power latch off; key off or watchdog event starts it.
// - Command registers loaded from data frames with selection bit zero.
// - Command bit one switches on; registers reset to zero.
// - Command one bits 7..0: inj1..4, out5, out20, out8, out19.
// - Command two: out15, out14, unused, then out9 and igniters 1..4.
// - Command three outputs 22,21,16,13,17,10,7,6; stepper uses bits 7 and 6.
// - Diagnostic fault bits clear when their register is read; event register bits clear only on the separate clear read.
// - Bridge select at reset one makes stepper bridges, zero single stages.
// - Stepper direction 0 forward, 1 back; enable 1 enables.
module dgoc_regs (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic                 power_on_reset,
  input  wire logic                 software_reset_command,
  input  wire logic                 reset_pin,
  input  wire logic                 start_command,
  input  wire logic                 power_latch_config,
  input  wire logic                 stepper_bridge_wr,
  input  wire logic                 stepper_bridge_wdata,
  input  wire dgoc_pkg::dgoc_cond_t cond,
  input  wire logic                 rd_stb,
  input  wire logic [3:0]           rd_addr,
  output logic [7:0]                rd_data,
  input  wire logic                 frame_stb,
  input  wire logic [8:0]           frame_data,
  input  wire logic [1:0]           frame_sel,
  output logic [7:0]                output_on_command_one,
  output logic [7:0]                output_on_command_two,
  output logic [7:0]                output_on_command_three,
  output logic                      stepper_dir,
  output logic                      stepper_enable,
  output logic                      stepper_bridge_select,
  output logic                      output_inhibit
);

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  logic rd_event;
  logic rd_event_clr;
  logic rd_supply;
  logic rd_cause;
  logic rd_thermal;
  logic rd_ign;
  assign rd_event     = rd_stb && (rd_addr == dgoc_pkg::ADDR_EVENT_KEYON);
  assign rd_event_clr = rd_stb && (rd_addr == dgoc_pkg::ADDR_EVENT_CLEAR);
  assign rd_supply    = rd_stb && (rd_addr == dgoc_pkg::ADDR_SUPPLY_SENSOR);
  assign rd_cause     = rd_stb && (rd_addr == dgoc_pkg::ADDR_RESET_CAUSE);
  assign rd_thermal   = rd_stb && (rd_addr == dgoc_pkg::ADDR_THERMAL_LINK);
  assign rd_ign       = rd_stb && (rd_addr == dgoc_pkg::ADDR_IGNITER);

  // ----------------------------------------------------------------
  // Live condition encoding
  // ----------------------------------------------------------------
  logic [1:0] sup_a_code;
  logic [1:0] sup_b_code;
  logic       crank_fault_live;
  always_comb begin
    // Overload outranks OV/OT
    if (cond.supply_a_overload_ovot[0]) begin
      sup_a_code = dgoc_pkg::SUP_OVERLOAD;
    end else if (cond.supply_a_overload_ovot[1]) begin
      sup_a_code = dgoc_pkg::SUP_OVER_V_T;
    end else begin
      sup_a_code = dgoc_pkg::SUP_HEALTHY;
    end
    if (cond.supply_b_overload_ovot[0]) begin
      sup_b_code = dgoc_pkg::SUP_OVERLOAD;
    end else if (cond.supply_b_overload_ovot[1]) begin
      sup_b_code = dgoc_pkg::SUP_OVER_V_T;
    end else begin
      sup_b_code = dgoc_pkg::SUP_HEALTHY;
    end
  end
  assign crank_fault_live = cond.crank_sensor_generic && cond.crank_fully_adaptive;

  // ----------------------------------------------------------------
  // Igniter codes: latest fault code held until read
  // ----------------------------------------------------------------
  logic [7:0] ign_q;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ign
      logic [1:0] live;
      assign live = cond.igniter_fault_code[2*gi +: 2];
      always_ff @(posedge mclk) begin
        if (reset) begin
          ign_q[2*gi +: 2] <= dgoc_pkg::IGN_HEALTHY;
        end else if (live != dgoc_pkg::IGN_HEALTHY) begin
          ign_q[2*gi +: 2] <= live;
        end else if (rd_ign) begin
          ign_q[2*gi +: 2] <= dgoc_pkg::IGN_HEALTHY;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Sticky fault flags: set wins over read clear
  // ----------------------------------------------------------------
  // Reset-cause register bits other than inhibit
  logic [6:0] cause_set;
  logic [6:0] cause_q;
  assign cause_set = {cond.timing_monitor_reset,
                      cond.main_outputs_fault,
                      cond.short_undervolt_reset,
                      cond.configurable_outputs_fault,
                      cond.logic5v_overvoltage,
                      cond.logic3v3_undervoltage,
                      cond.battery_overvolt_shutdown};
  logic [7:0] therm_set;
  logic [7:0] therm_q;
  assign therm_set = {cond.overtemp,
                      cond.long_undervolt_event,
                      |cond.can_errors,
                      cond.frame_length_error,
                      cond.frame_timeout_error};
  logic crank_q;

  genvar gc;
  generate
    for (gc = 0; gc < 7; gc++) begin : g_cause
      always_ff @(posedge mclk) begin
        if (reset) begin
          cause_q[gc] <= 1'b0;
        end else if (cause_set[gc]) begin
          cause_q[gc] <= 1'b1;
        end else if (rd_cause) begin
          cause_q[gc] <= 1'b0;
        end
      end
    end
    for (gc = 0; gc < 8; gc++) begin : g_therm
      always_ff @(posedge mclk) begin
        if (reset) begin
          therm_q[gc] <= 1'b0;
        end else if (therm_set[gc]) begin
          therm_q[gc] <= 1'b1;
        end else if (rd_thermal) begin
          therm_q[gc] <= 1'b0;
        end
      end
    end
  endgenerate

  // Sticky like the others; a supply register read clears it
  always_ff @(posedge mclk) begin
    if (reset) begin
      crank_q <= 1'b0;
    end else if (crank_fault_live) begin
      crank_q <= 1'b1;
    end else if (rd_supply) begin
      crank_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output inhibit
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset || power_on_reset || software_reset_command || reset_pin) begin
      output_inhibit <= 1'b1;
    end else if (start_command) begin
      output_inhibit <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // I/O undervoltage qualifier
  // ----------------------------------------------------------------
  localparam logic [22:0] IO_UV_LIMIT = 23'(dgoc_pkg::IO_UV_CYCLES);
  // Saturates one past the limit so the set condition holds steadily
  logic [22:0] io_uv_cnt_q;
  logic        io_uv_q;
  always_ff @(posedge mclk) begin
    if (reset || !cond.io_supply_low) begin
      io_uv_cnt_q <= '0;
    end else if (io_uv_cnt_q <= IO_UV_LIMIT) begin
      io_uv_cnt_q <= io_uv_cnt_q + 23'h000001;
    end
  end

  // ----------------------------------------------------------------
  // Safe engine off sequencing
  // ----------------------------------------------------------------
  // Counts span millions of cycles, out of reach of short test runs
  localparam logic [23:0] SEO_INJ_LIMIT   = 24'(dgoc_pkg::SEO_INJ_CYC);
  localparam logic [23:0] SEO_RELAY_LIMIT = 24'(dgoc_pkg::SEO_RELAY_CYC);
  dgoc_pkg::dgoc_seo_t seo_state_q;
  logic [23:0]         seo_cnt_q;
  logic                seo_inj_q;
  logic                seo_relay_q;
  logic                wdg_latched_q;
  logic                wdg_prev_q;
  logic                wdg_rise;
  logic                seo_trigger;
  assign wdg_rise    = cond.watchdog_alarm && !wdg_prev_q;
  // Only with power latch disabled; watchdog overrides a high key
  assign seo_trigger = !power_latch_config && (!cond.filtered_key_on || wdg_rise);

  always_ff @(posedge mclk) begin
    if (reset) begin
      seo_state_q <= dgoc_pkg::SEO_IDLE;
      seo_cnt_q   <= '0;
    end else begin
      case (seo_state_q)
        dgoc_pkg::SEO_IDLE: begin
          seo_cnt_q <= '0;
          if (seo_trigger) begin
            seo_state_q <= dgoc_pkg::SEO_COUNT;
          end
        end
        dgoc_pkg::SEO_COUNT: begin
          seo_cnt_q <= seo_cnt_q + 24'h000001;
          if (power_latch_config) begin
            seo_state_q <= dgoc_pkg::SEO_IDLE;
          end else if (seo_cnt_q >= SEO_RELAY_LIMIT) begin
            seo_state_q <= dgoc_pkg::SEO_DONE;
          end
        end
        dgoc_pkg::SEO_DONE: begin
          // Rearm when key returns without a pending watchdog
          if (cond.filtered_key_on && !cond.watchdog_alarm) begin
            seo_state_q <= dgoc_pkg::SEO_IDLE;
          end
        end
        default: begin
          seo_state_q <= dgoc_pkg::SEO_IDLE;
        end
      endcase
    end
  end

  // Event register: cleared only by the separate clear read
  always_ff @(posedge mclk) begin
    if (reset) begin
      io_uv_q       <= 1'b0;
      seo_inj_q     <= 1'b0;
      seo_relay_q   <= 1'b0;
      wdg_latched_q <= 1'b0;
      wdg_prev_q    <= 1'b0;
    end else begin
      wdg_prev_q <= cond.watchdog_alarm;
      if (io_uv_cnt_q > IO_UV_LIMIT) begin
        io_uv_q <= 1'b1;
      end else if (rd_event_clr) begin
        io_uv_q <= 1'b0;
      end
      if (wdg_rise) begin
        wdg_latched_q <= 1'b1;
      end else if (rd_event_clr) begin
        wdg_latched_q <= 1'b0;
      end
      if (seo_state_q == dgoc_pkg::SEO_COUNT && seo_cnt_q == SEO_INJ_LIMIT) begin
        seo_inj_q <= 1'b1;
      end else if (rd_event_clr) begin
        seo_inj_q <= 1'b0;
      end
      if (seo_state_q == dgoc_pkg::SEO_COUNT && seo_cnt_q == SEO_RELAY_LIMIT) begin
        seo_relay_q <= 1'b1;
      end else if (rd_event_clr) begin
        seo_relay_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_data <= 8'h00;
    end else if (rd_stb) begin
      case (rd_addr)
        dgoc_pkg::ADDR_EVENT_KEYON: begin
          rd_data <= {io_uv_q, wdg_latched_q, seo_inj_q, seo_relay_q,
                      cond.watchdog_alarm, 2'b00, cond.filtered_key_on};
        end
        dgoc_pkg::ADDR_SUPPLY_SENSOR: begin
          rd_data <= {cond.key_on_above, cond.relay_driver_overcurrent_off,
                      cond.crank_sensor_diag_running, crank_q, sup_b_code, sup_a_code};
        end
        dgoc_pkg::ADDR_RESET_CAUSE: begin
          // Inhibit sits in bit 1 and is never cleared by reads
          rd_data <= {cause_q[6:1], output_inhibit, cause_q[0]};
        end
        dgoc_pkg::ADDR_THERMAL_LINK: begin
          rd_data <= therm_q;
        end
        dgoc_pkg::ADDR_IGNITER: begin
          rd_data <= ign_q;
        end
        default: begin
          rd_data <= 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command registers from downstream data frames
  // ----------------------------------------------------------------
  logic       frame_ok;
  logic [7:0] frame_payload;
  // Bit 0 arrives first and must be 0 for a data frame
  assign frame_ok      = frame_stb && !frame_data[0];
  assign frame_payload = frame_data[8:1];

  always_ff @(posedge mclk) begin
    if (reset || power_on_reset || software_reset_command || reset_pin) begin
      output_on_command_one   <= dgoc_pkg::CMD_RESET;
      output_on_command_two   <= dgoc_pkg::CMD_RESET;
      output_on_command_three <= dgoc_pkg::CMD_RESET;
    end else if (output_inhibit) begin
      // Data for the stages is dropped while inhibited
      output_on_command_one   <= dgoc_pkg::CMD_RESET;
      output_on_command_two   <= dgoc_pkg::CMD_RESET;
      output_on_command_three <= dgoc_pkg::CMD_RESET;
    end else if (frame_ok) begin
      case (frame_sel)
        dgoc_pkg::SEL_CMD_ONE: begin
          output_on_command_one <= frame_payload;
        end
        dgoc_pkg::SEL_CMD_TWO: begin
          output_on_command_two <= frame_payload;
          output_on_command_two[dgoc_pkg::CMD2_UNUSED_BIT] <= 1'b0;
        end
        dgoc_pkg::SEL_CMD_THREE: begin
          output_on_command_three <= frame_payload;
        end
        default: begin
          output_on_command_one <= output_on_command_one;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      stepper_bridge_select <= dgoc_pkg::STEPPER_BRIDGE_RESET;
    end else if (stepper_bridge_wr) begin
      stepper_bridge_select <= stepper_bridge_wdata;
    end
  end

  // Bits 7 and 6 of command three double as stepper controls
  assign stepper_dir    = stepper_bridge_select &&
                          output_on_command_three[dgoc_pkg::CMD3_DIR_BIT];
  assign stepper_enable = stepper_bridge_select &&
                          output_on_command_three[dgoc_pkg::CMD3_EN_BIT];

endmodule

// ==== bench/dgoc_regs_chk.sv ====
// Checker for the diagnostic and output command register bank
`timescale 1ns/1ps
module dgoc_regs_chk (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       power_on_reset,
  input wire logic       software_reset_command,
  input wire logic       reset_pin,
  input wire logic       start_command,
  input wire logic       rd_stb,
  input wire logic [3:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic       frame_stb,
  input wire logic [8:0] frame_data,
  input wire logic [1:0] frame_sel,
  input wire logic [7:0] output_on_command_one,
  input wire logic [7:0] output_on_command_two,
  input wire logic [7:0] output_on_command_three,
  input wire logic       stepper_dir,
  input wire logic       stepper_enable,
  input wire logic       stepper_bridge_select,
  input wire logic       output_inhibit
);
  // ----
  // Properties
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire        rsrc = power_on_reset | software_reset_command | reset_pin;
  wire [23:0] cmds = {output_on_command_one, output_on_command_two, output_on_command_three};
  a_inhibit_blocks_out: assert property (output_inhibit |-> cmds == 24'h0)
    else $error("command active while inhibited");
  a_cmd_two_spare: assert property (output_on_command_two[5] == 1'b0)
    else $error("spare command bit set");
  a_frame_loads_one: assert property (frame_stb && !frame_data[0] && frame_sel == 2'h0
    && !output_inhibit && !rsrc |=> output_on_command_one == $past(frame_data[8:1]))
    else $error("data frame not loaded");
  a_bad_frame_kept: assert property (frame_stb && frame_data[0] && !rsrc |=> $stable(cmds))
    else $error("non-data frame changed commands");
  a_rst_src_inhibit: assert property (rsrc |=> output_inhibit && cmds == 24'h0)
    else $error("reset source did not inhibit");
  a_start_enables: assert property (start_command && !rsrc |=> !output_inhibit)
    else $error("start did not release outputs");
  a_inhibit_sticky: assert property (output_inhibit && !start_command |=> output_inhibit)
    else $error("inhibit cleared without start");
  a_stepper_decode: assert property (stepper_dir == (stepper_bridge_select
    & output_on_command_three[7]) && stepper_enable == (stepper_bridge_select
    & output_on_command_three[6])) else $error("stepper decode wrong");
  a_event_clear_zero: assert property (rd_stb && rd_addr == dgoc_pkg::ADDR_EVENT_CLEAR
    |=> rd_data == 8'h00) else $error("clear read returned data");
  a_cause_inhibit_bit: assert property (rd_stb && rd_addr == dgoc_pkg::ADDR_RESET_CAUSE
    |=> rd_data[1] == $past(output_inhibit)) else $error("inhibit bit misread");
  c_frame_taken: cover property (frame_stb && !frame_data[0] && !output_inhibit);
  c_start: cover property (start_command && output_inhibit);
  c_cause_read: cover property (rd_stb && rd_addr == dgoc_pkg::ADDR_RESET_CAUSE);
endmodule
bind dgoc_regs dgoc_regs_chk dgoc_regs_chk_inst (.mclk, .reset, .power_on_reset,
  .software_reset_command, .reset_pin, .start_command, .rd_stb, .rd_addr, .rd_data,
  .frame_stb, .frame_data, .frame_sel, .output_on_command_one, .output_on_command_two,
  .output_on_command_three, .stepper_dir, .stepper_enable, .stepper_bridge_select,
  .output_inhibit);

// ==== bench/dgoc_host.sv ====
// Host model issuing read commands, data frames and the start command
`timescale 1ns/1ps
module dgoc_host (
  input  wire logic       mclk,
  input  wire logic [7:0] rd_data,
  output logic            rd_stb,
  output logic [3:0]      rd_addr,
  output logic            frame_stb,
  output logic [8:0]      frame_data,
  output logic [1:0]      frame_sel,
  output logic            start_command
);
  initial begin
    rd_stb = 1'b0;
    rd_addr = 4'h0;
    frame_stb = 1'b0;
    frame_data = 9'h0;
    frame_sel = 2'h0;
    start_command = 1'b0;
  end
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge mclk);
    rd_stb = 1'b1;
    rd_addr = a;
    @(negedge mclk);
    rd_stb = 1'b0;
    // Released address toggles so stale values are not trusted
    rd_addr = ~a;
    d = rd_data;
  endtask
  task automatic frame(input logic [1:0] s, input logic [7:0] p, input logic b0);
    @(negedge mclk);
    frame_stb = 1'b1;
    frame_sel = s;
    frame_data = {p, b0};
    @(negedge mclk);
    frame_stb = 1'b0;
    frame_data = ~frame_data;
  endtask
  task automatic start();
    @(negedge mclk);
    start_command = 1'b1;
    @(negedge mclk);
    start_command = 1'b0;
  endtask
endmodule

// ==== bench/tb_diag_and_output_command_regs.sv ====
// Self-checking bench for the diagnostic and output command register bank
`timescale 1ns/1ps
module tb_diag_and_output_command_regs;
  logic                 mclk, reset, power_on_reset, software_reset_command, reset_pin;
  logic                 power_latch_config, stepper_bridge_wr, stepper_bridge_wdata;
  logic                 rd_stb, frame_stb, start_command, stepper_dir, stepper_enable;
  logic                 stepper_bridge_select, output_inhibit;
  logic [3:0]           rd_addr;
  logic [7:0]           rd_data, output_on_command_one, output_on_command_two;
  logic [7:0]           output_on_command_three;
  logic [8:0]           frame_data;
  logic [1:0]           frame_sel;
  dgoc_pkg::dgoc_cond_t cond, base;
  int                   error_cnt, tests_run, cycles;
  dgoc_regs dgoc_regs_inst (.mclk, .reset, .power_on_reset, .software_reset_command,
    .reset_pin, .start_command, .power_latch_config, .stepper_bridge_wr,
    .stepper_bridge_wdata, .cond, .rd_stb, .rd_addr, .rd_data, .frame_stb, .frame_data,
    .frame_sel, .output_on_command_one, .output_on_command_two, .output_on_command_three,
    .stepper_dir, .stepper_enable, .stepper_bridge_select, .output_inhibit);
  dgoc_host host_inst (.mclk, .rd_data, .rd_stb, .rd_addr, .frame_stb, .frame_data,
    .frame_sel, .start_command);
  // ----
  // Tasks
  // ----
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host_inst.rd(a, v);
    chk8(v, exp);
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      $display("[FAIL] %0t run did not finish", $time);
      end_sim();
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    {reset, power_latch_config} = 2'b11;
    {power_on_reset, software_reset_command, reset_pin} = 3'b000;
    {stepper_bridge_wr, stepper_bridge_wdata} = 2'b00;
    cond = '0;
    cond.igniter_fault_code = 8'hff;
    repeat (6) @(negedge mclk);
    reset = 1'b0;
    chk8({6'h0, output_inhibit, stepper_bridge_select}, 8'h03);
    chk8(output_on_command_one | output_on_command_two | output_on_command_three, 8'h00);
    rdchk(dgoc_pkg::ADDR_RESET_CAUSE, 8'h02);
    rdchk(dgoc_pkg::ADDR_RESET_CAUSE, 8'h02);
    host_inst.frame(dgoc_pkg::SEL_CMD_ONE, 8'hff, 1'b0);
    chk8(output_on_command_one, 8'h00);
    for (int k = 0; k < 3; k++) begin
      host_inst.start();
      host_inst.frame(dgoc_pkg::SEL_CMD_ONE, 8'ha5, 1'b0);
      chk8(output_on_command_one, 8'ha5);
      @(negedge mclk);
      {power_on_reset, software_reset_command, reset_pin} = 3'b100 >> k;
      @(negedge mclk);
      {power_on_reset, software_reset_command, reset_pin} = 3'b000;
      chk8({output_inhibit, output_on_command_one[6:0]}, 8'h80);
    end
    host_inst.start();
    host_inst.frame(dgoc_pkg::SEL_CMD_TWO, 8'hff, 1'b0);
    host_inst.frame(dgoc_pkg::SEL_CMD_THREE, 8'hff, 1'b0);
    chk8(output_on_command_two, 8'hdf);
    chk8({output_on_command_three[5:0], stepper_dir, stepper_enable}, 8'hff);
    host_inst.frame(dgoc_pkg::SEL_CMD_THREE, 8'h40, 1'b0);
    host_inst.frame(dgoc_pkg::SEL_CMD_THREE, 8'h00, 1'b1);
    host_inst.frame(2'h3, 8'h00, 1'b0);
    chk8({output_on_command_three[7:2], stepper_dir, stepper_enable}, 8'h41);
    @(negedge mclk);
    stepper_bridge_wr = 1'b1;
    @(negedge mclk);
    stepper_bridge_wr = 1'b0;
    host_inst.frame(dgoc_pkg::SEL_CMD_THREE, 8'hc0, 1'b0);
    chk8({output_on_command_three[7:2], stepper_dir, stepper_enable}, 8'hc0);
    // Igniter, reset-cause, thermal and CAN faults are one-cycle pulses to prove they are latched
    base = cond;
    cond.igniter_fault_code = 8'h1b;
    @(negedge mclk);
    cond = base;
    rdchk(dgoc_pkg::ADDR_IGNITER, 8'h1b);
    rdchk(dgoc_pkg::ADDR_IGNITER, 8'hff);
    {cond.key_on_above, cond.relay_driver_overcurrent_off} = 2'b11;
    {cond.crank_sensor_diag_running, cond.crank_sensor_generic} = 2'b11;
    {cond.supply_a_overload_ovot, cond.supply_b_overload_ovot} = 4'hf;
    cond.supply_b_overload_ovot = 2'b10;
    rdchk(dgoc_pkg::ADDR_SUPPLY_SENSOR, 8'he9);
    cond.crank_fully_adaptive = 1'b1;
    rdchk(dgoc_pkg::ADDR_SUPPLY_SENSOR, 8'hf9);
    cond = base;
    rdchk(dgoc_pkg::ADDR_SUPPLY_SENSOR, 8'h1f);
    rdchk(dgoc_pkg::ADDR_SUPPLY_SENSOR, 8'h0f);
    {cond.timing_monitor_reset, cond.main_outputs_fault, cond.short_undervolt_reset} = 3'h7;
    {cond.configurable_outputs_fault, cond.logic5v_overvoltage} = 2'h3;
    {cond.logic3v3_undervoltage, cond.battery_overvolt_shutdown} = 2'h3;
    @(negedge mclk);
    cond = base;
    rdchk(dgoc_pkg::ADDR_RESET_CAUSE, 8'hfd);
    rdchk(dgoc_pkg::ADDR_RESET_CAUSE, 8'h00);
    {cond.overtemp, cond.long_undervolt_event} = 5'h1f;
    {cond.frame_length_error, cond.frame_timeout_error} = 2'h3;
    @(negedge mclk);
    cond = base;
    rdchk(dgoc_pkg::ADDR_THERMAL_LINK, 8'hfb);
    for (int i = 0; i < 4; i++) begin
      cond.can_errors = 4'h1 << i;
      @(negedge mclk);
      cond = base;
      rdchk(dgoc_pkg::ADDR_THERMAL_LINK, 8'h04);
    end
    {cond.filtered_key_on, cond.watchdog_alarm} = 2'h3;
    rdchk(dgoc_pkg::ADDR_EVENT_KEYON, 8'h49);
    cond.watchdog_alarm = 1'b0;
    rdchk(dgoc_pkg::ADDR_EVENT_KEYON, 8'h41);
    rdchk(dgoc_pkg::ADDR_EVENT_CLEAR, 8'h00);
    rdchk(dgoc_pkg::ADDR_EVENT_KEYON, 8'h01);
    end_sim();
  end
endmodule
